// ===== hdl/aseh_pkg.sv
// What this block does
// - busy low 40 clocks after the last start
// - start while busy restarts conversion
// - requester waits 4 clocks after done
// - starts in 4-clock guard may drop
// - result moves to latches at done
// - direct loopback oscillates; guard covers it
// - free-run via flip-flop, clear stops
// - latch request, delay 4 stages
// - clear latch one clock after busy
// - start pulse exactly one clock wide
// - async request; held high runs continuously in the count scheme
// - counter loaded with 11 at start
// - counter holds until done rises
// - carry 4 clocks after done, clears latch
// - carry pulse signals data ready
// - zero end reads ff then fe
// - full scale reads 01 then 00
// - start pulse 1 to 3.5 clocks
// - latches hold old result until new
// - results in complementary binary
package aseh_pkg;
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned CONV_CLOCKS    = 40;
    localparam int unsigned GUARD_CLOCKS   = 4;
    localparam int unsigned DELAY_STAGES   = 4;
    localparam logic [3:0]  CNT_LOAD       = 4'hb;
    localparam logic [3:0]  CNT_CARRY      = 4'hf;
    localparam logic [5:0]  CONV_LAST      = 6'(CONV_CLOCKS - 1);
    localparam logic [2:0]  GUARD_LAST     = 3'(GUARD_CLOCKS - 1);
    localparam logic [7:0]  CODE_ZERO      = 8'hff;
    localparam logic [7:0]  CODE_FULL      = 8'h00;
    typedef enum logic [1:0] {ASEH_IDLE, ASEH_BUSY, ASEH_GUARD} aseh_state_t;
    typedef enum logic {ASEH_SCHEME_SHIFT, ASEH_SCHEME_COUNT} aseh_scheme_t;
endpackage

// ===== hdl/aseh_if.sv
`timescale 1ns/1ps
interface aseh_if;
    logic       start;
    logic       conv_done;
    logic [7:0] result;
    modport conv (input start, output conv_done, output result);
    modport ctrl (output start, input conv_done, input result);
endinterface

// ===== hdl/aseh_conv.sv
`timescale 1ns/1ps
module aseh_conv (
    input  wire logic   clk,
    input  wire logic   rst,
    aseh_if.conv        link,
    input  wire logic [7:0] sample_code,
    output logic        busy
);
    aseh_pkg::aseh_state_t state_reg;
    logic [5:0] cnt_reg;
    logic [7:0] successive_approx_register;
    logic [7:0] result_reg;
    logic       done_reg;

    // conversion sequencing; start in guard dropped, start while busy restarts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= aseh_pkg::ASEH_IDLE;
            cnt_reg   <= 6'h00;
        end else begin
            unique case (state_reg)
                aseh_pkg::ASEH_IDLE: begin
                    if (link.start) begin
                        state_reg <= aseh_pkg::ASEH_BUSY;
                        cnt_reg   <= 6'h00;
                    end
                end
                aseh_pkg::ASEH_BUSY: begin
                    if (link.start) begin
                        cnt_reg <= 6'h00;
                    end else if (cnt_reg == aseh_pkg::CONV_LAST) begin
                        state_reg <= aseh_pkg::ASEH_GUARD;
                        cnt_reg   <= 6'h00;
                    end else begin
                        cnt_reg <= cnt_reg + 6'h01;
                    end
                end
                aseh_pkg::ASEH_GUARD: begin
                    // ignoring start here tames a looped-back done line
                    if (cnt_reg[2:0] == aseh_pkg::GUARD_LAST) begin
                        state_reg <= aseh_pkg::ASEH_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 6'h01;
                    end
                end
            endcase
        end
    end

    // approximation value: sample taken, cleared on restart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            successive_approx_register <= 8'h00;
        end else if (link.start && state_reg != aseh_pkg::ASEH_GUARD) begin
            successive_approx_register <= 8'h00;
        end else if (state_reg == aseh_pkg::ASEH_BUSY) begin
            successive_approx_register <= ~sample_code;
        end
    end

    // output latches load only at completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_reg <= aseh_pkg::CODE_ZERO;
        end else if (state_reg == aseh_pkg::ASEH_BUSY && !link.start && cnt_reg == aseh_pkg::CONV_LAST) begin
            result_reg <= successive_approx_register;
        end
    end

    // done high when not busy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_reg <= 1'b1;
            busy     <= 1'b0;
        end else begin
            done_reg <= !(state_reg == aseh_pkg::ASEH_BUSY && !(cnt_reg == aseh_pkg::CONV_LAST && !link.start))
                        && !(state_reg == aseh_pkg::ASEH_IDLE && link.start);
            busy     <= (state_reg == aseh_pkg::ASEH_BUSY && !(cnt_reg == aseh_pkg::CONV_LAST && !link.start))
                        || (state_reg == aseh_pkg::ASEH_IDLE && link.start);
        end
    end

    assign link.conv_done = done_reg;
    assign link.result    = result_reg;
endmodule

// ===== hdl/aseh_ctrl.sv
`timescale 1ns/1ps
module aseh_ctrl (
    input  wire logic       clk,
    input  wire logic       rst,
    aseh_if.ctrl            link,
    input  wire logic       scheme,
    input  wire logic       free_run,
    input  wire logic       free_clear,
    input  wire logic       request,
    output logic            ready,
    output logic [7:0]      data
);
    logic       req_latch_reg;
    logic [3:0] shift_reg;
    logic       done_d_reg;
    logic       done_seen_reg;
    logic       free_ff_reg;
    logic [3:0] count_reg;
    logic       counting_reg;
    logic       start_reg;
    logic       pending_reg;
    logic [2:0] free_dly_reg;
    logic       carry;
    logic       done_rise;

    assign done_rise = link.conv_done && !done_d_reg;
    assign carry     = counting_reg && count_reg == aseh_pkg::CNT_CARRY;

    // edge history of done, all on converter clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_d_reg    <= 1'b1;
            done_seen_reg <= 1'b0;
        end else begin
            done_d_reg    <= link.conv_done;
            // busy level one clock late; a request in mid-conversion still reaches the delay chain and restarts
            done_seen_reg <= !link.conv_done;
        end
    end

    // request latch; set wins over clear so no request is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_latch_reg <= 1'b0;
        end else if (request) begin
            req_latch_reg <= 1'b1;
        end else if (scheme == aseh_pkg::ASEH_SCHEME_SHIFT ? done_seen_reg : carry) begin
            req_latch_reg <= 1'b0;
        end
    end

    // delay chain for the shift scheme
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_reg <= 4'h0;
        end else begin
            shift_reg <= {shift_reg[2:0], req_latch_reg && !pending_reg};
        end
    end

    // one start per request until conversion acknowledged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending_reg <= 1'b0;
        end else if (start_reg) begin
            pending_reg <= 1'b1;
        end else if (scheme == aseh_pkg::ASEH_SCHEME_SHIFT ? done_seen_reg : carry) begin
            pending_reg <= 1'b0;
        end
    end

    // counter loaded at start, held until done rises
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg    <= 4'h0;
            counting_reg <= 1'b0;
        end else if (start_reg) begin
            count_reg    <= aseh_pkg::CNT_LOAD;
            counting_reg <= 1'b0;
        end else if (carry) begin
            counting_reg <= 1'b0;
        end else if (done_rise || counting_reg) begin
            counting_reg <= 1'b1;
            count_reg    <= count_reg + 4'h1;
        end
    end

    // free-run flip-flop samples done; delay keeps the restart out of the guard
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            free_ff_reg  <= 1'b0;
            free_dly_reg <= 3'h0;
        end else if (free_clear) begin
            free_ff_reg  <= 1'b0;
            free_dly_reg <= 3'h0;
        end else begin
            free_ff_reg  <= free_run && done_rise;
            free_dly_reg <= {free_dly_reg[1:0], free_ff_reg};
        end
    end

    // single-clock start pulse; edge-triggered in free-run and shift, repeated while the request latch holds in count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_reg <= 1'b0;
        end else if (free_run && free_dly_reg[2]) begin
            start_reg <= 1'b1;
        end else if (scheme == aseh_pkg::ASEH_SCHEME_SHIFT) begin
            // leading edge of the delayed request, so one pulse per request
            start_reg <= shift_reg[2] && !shift_reg[3];
        end else begin
            start_reg <= req_latch_reg && !pending_reg && !start_reg && !counting_reg;
        end
    end

    // ready pulse and captured data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready <= 1'b0;
            data  <= 8'h00;
        end else begin
            ready <= carry;
            if (done_rise) begin
                data <= link.result;
            end
        end
    end

    assign link.start = start_reg;
endmodule

// ===== test/aseh_props.sv
`timescale 1ns/1ps
module aseh_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       start,
    input wire logic       conv_done,
    input wire logic [7:0] result
);
    logic [5:0] low_cnt_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // busy cycles since the last start; a restart clears it so the span is per conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_reg <= 6'h00;
        end else if (start || conv_done) begin
            low_cnt_reg <= 6'h00;
        end else begin
            low_cnt_reg <= low_cnt_reg + 6'h01;
        end
    end
    property p_start_one; start |=> !start; endproperty
    a_start_one: assert property (p_start_one) else $error("start pulse wider than one clock");
    property p_take_idle; start && conv_done && $past(conv_done, 5) |=> !conv_done; endproperty
    a_take_idle: assert property (p_take_idle) else $error("start outside guard not taken");
    property p_restart; start && !conv_done |=> !conv_done [*8]; endproperty
    a_restart: assert property (p_restart) else $error("restart did not keep busy");
    property p_conv_len; $rose(conv_done) |-> low_cnt_reg == 6'h28; endproperty
    a_conv_len: assert property (p_conv_len) else $error("busy span not 40 cycles");
    property p_fall_cause; $fell(conv_done) |-> $past(start); endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("busy without start");
    property p_hold; !$rose(conv_done) |-> $stable(result); endproperty
    a_hold: assert property (p_hold) else $error("result moved outside completion");
    property p_guard; $rose(conv_done) |-> !start [*4]; endproperty
    a_guard: assert property (p_guard) else $error("start inside guard interval");
    property p_done_stays; conv_done && !start |=> conv_done; endproperty
    a_done_stays: assert property (p_done_stays) else $error("done dropped without start");
    c_restart: cover property (start && !conv_done);
    c_finish: cover property ($rose(conv_done));
    c_begin: cover property (start && conv_done);
endmodule

// ===== test/aseh_tb_top.sv
`timescale 1ns/1ps
module aseh_tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       scheme = 1'b0;
    logic       free_run = 1'b0;
    logic       free_clear = 1'b0;
    logic       request = 1'b0;
    logic [7:0] sample_code = 8'h00;
    logic       busy;
    logic       ready;
    logic [7:0] data;
    int         n_errors = 0;
    int         compares = 0;
    aseh_if link ();
    aseh_conv u_aseh_conv (.clk(clk), .rst(rst), .link(link), .sample_code(sample_code), .busy(busy));
    aseh_ctrl u_aseh_ctrl (.clk(clk), .rst(rst), .link(link), .scheme(scheme), .free_run(free_run),
        .free_clear(free_clear), .request(request), .ready(ready), .data(data));
    aseh_props u_aseh_props (.clk(clk), .rst(rst), .start(link.start), .conv_done(link.conv_done),
        .result(link.result));
    // 20 mhz converter clock
    always #25 clk = ~clk;
    task automatic conclude;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for a done level; a hang ends the run
    task automatic wait_done(input logic lvl, output int n);
        n = 0;
        while (link.conv_done !== lvl && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n == 200) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic count_starts(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge clk);
            if (link.start === 1'b1) n++;
        end
    endtask
    // short request, well under one conversion time
    task automatic pulse_req;
        request = 1'b1;
        repeat (2) @(negedge clk);
        request = 1'b0;
    endtask
    // scale-end codes; 8 idle cycles keep the next request past the guard
    task automatic run_codes(input logic sch);
        logic [7:0] codes [4] = '{8'h00, 8'h01, 8'hfe, 8'hff};
        int n;
        int hit;
        scheme = sch;
        foreach (codes[k]) begin
            sample_code = codes[k];
            pulse_req();
            wait_done(1'b0, n);
            chk8("busy high", 8'h01, {7'h00, busy});
            wait_done(1'b1, n);
            chk8("busy low", 8'h00, {7'h00, busy});
            hit = 0;
            repeat (8) begin
                @(negedge clk);
                if (ready === 1'b1) hit++;
            end
            chk8("data", ~codes[k], data);
            if (sch) chk8("ready pulses", 8'h01, 8'(hit));
        end
    endtask
    task automatic restart;
        int n;
        scheme = 1'b0;
        sample_code = 8'h5a;
        pulse_req();
        wait_done(1'b0, n);
        repeat (10) @(negedge clk);
        sample_code = 8'h3c;
        pulse_req();
        wait_done(1'b1, n);
        repeat (8) @(negedge clk);
        chk8("restart data", 8'hc3, data);
        chk8("restart long", 8'h01, 8'(n > 30));
    endtask
    task automatic free_mode;
        int n;
        scheme = 1'b0;
        free_run = 1'b1;
        pulse_req();
        count_starts(200, n);
        chk8("free starts", 8'h01, 8'(n >= 3));
        free_clear = 1'b1;
        repeat (60) @(negedge clk);
        count_starts(100, n);
        chk8("stopped starts", 8'h00, 8'(n));
        free_run = 1'b0;
        free_clear = 1'b0;
    endtask
    task automatic hold_run;
        int n;
        scheme = 1'b1;
        request = 1'b1;
        count_starts(200, n);
        request = 1'b0;
        chk8("held starts", 8'h01, 8'(n >= 3));
        repeat (100) @(negedge clk);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        run_codes(1'b0);
        run_codes(1'b1);
        restart();
        free_mode();
        hold_run();
        conclude();
    end
endmodule
